// ### cscc_pkg.sv
// Package for the configuration status and chain-enable control block.
// Assumes one 20 MHz clock and a synchronous active-high reset.
package cscc_pkg;

	// =========================================
	// Flow states
	typedef enum logic [2:0] {
		ST_RESET = 3'h0,
		ST_CONFIG = 3'h1,
		ST_WAIT_DONE = 3'h2,
		ST_INIT = 3'h3,
		ST_USER = 3'h4,
		ST_ERROR = 3'h5
	} cscc_state_t;

	// =========================================
	// Scheme encoding
	typedef enum logic [1:0] {
		SCH_PASSIVE = 2'h0,
		SCH_ACTIVE_SERIAL = 2'h1,
		SCH_ACTIVE_PARALLEL = 2'h2
	} cscc_scheme_t;

	// =========================================
	// Timing
	localparam int CLK_HZ = 20000000;
	localparam int INIT_TIME_NS = 1000;
	localparam int INIT_CYCLES = (INIT_TIME_NS * (CLK_HZ / 1000000) + 999) / 1000;
	localparam logic [7:0] INIT_COUNT = 8'(INIT_CYCLES);
	localparam logic [7:0] INIT_COUNT_RST = 8'h00;

	// =========================================
	// Reset values
	localparam logic RECONF_PREV_RST = 1'b1;
	localparam logic DONE_DRIVE_RST = 1'b1;
	localparam logic CEO_DRIVE_RST = 1'b0;
	localparam logic FSEL_N_RST = 1'b1;
	localparam logic ERR_DRIVE_RST = 1'b0;

endpackage : cscc_pkg

// ### cscc_init_timer.sv
// Initialization cycle timer: counts a fixed number of cycles once started.
// Assumes start stays high while the caller is in its initialization state.
module cscc_init_timer
	import cscc_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic srst_i,
	// Control
	input wire logic run_i,
	output logic done_o
);

	logic [7:0] count_r;
	logic [7:0] count_nxt;

	assign count_nxt = run_i ? ((count_r == INIT_COUNT) ? count_r : count_r + 8'h01) : INIT_COUNT_RST;
	assign done_o = (count_r == INIT_COUNT);

	always_ff @(posedge clk_i)
	begin
		if (srst_i)
			count_r <= INIT_COUNT_RST;
		else
			count_r <= count_nxt;
	end

endmodule : cscc_init_timer

// ### cscc_ctrl.sv
// Configuration status and chain-enable control of a programmable device.
// Assumes the configuration engine reports data_done_i and crc_err_i, and that
// inputs are synchronous to clk_i; open-drain pins are split into in/out/oe, the chain-enable output into out/oe only.
//
// What this block does
// - The done status line is held low from before configuration and all through it.
// - When all data arrived without error, the done line is released, before initialization starts.
// - Initialization and user mode start only after all data arrived and the done line reads high.
// - After initialization, external low levels on the done line are ignored and the state holds.
// - Configuration proceeds only while the chain-enable input is low.
// - The chain-enable output drives low when this device's configuration completes.
// - With the dual-purpose option the chain-enable output is released once user mode is entered.
// - In active serial scheme the flash select enables the serial memory while reading.
// - In active parallel scheme the same flash select is the parallel flash chip enable.
// - A rising reconfiguration request after a low discards the configuration and restarts.
// - An external low on the error line in configuration or initialization enters the error state.
module cscc_ctrl
	import cscc_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic srst_i,
	// Configuration engine
	input wire cscc_scheme_t scheme_i,
	input wire logic dual_purpose_i,
	input wire logic data_done_i,
	input wire logic crc_err_i,
	output logic config_active_o,
	output logic user_mode_o,
	output logic error_o,
	// Reconfiguration request and chain enable
	input wire logic reconfig_request_n_i,
	input wire logic chain_enable_in_n_i,
	// Done status open-drain pin
	input wire logic config_done_status_i,
	output logic config_done_status_o,
	output logic config_done_status_oe_o,
	// Error status open-drain pin
	input wire logic config_error_n_i,
	output logic config_error_n_o,
	output logic config_error_n_oe_o,
	// Chain-enable output open-drain pin
	output logic chain_enable_out_n_o,
	output logic chain_enable_out_n_oe_o,
	// Flash select
	output logic flash_select_n_o
);

	// =========================================
	// State and registers
	cscc_state_t state_r;
	cscc_state_t state_nxt;
	logic reconf_prev_r;
	logic done_drive_r;
	logic done_drive_nxt;
	logic ceo_drive_r;
	logic ceo_drive_nxt;
	logic fsel_n_r;
	logic fsel_n_nxt;
	logic err_drive_r;
	logic err_drive_nxt;
	logic init_done;

	// =========================================
	// Decodes
	wire reconf_rise = reconf_prev_r == 1'b0 && reconfig_request_n_i == 1'b1;
	wire reconf_low = ~reconfig_request_n_i;
	wire chain_ok = ~chain_enable_in_n_i;
	// Error line low only counts when this block is not the one pulling it
	wire ext_error = ~config_error_n_i && ~err_drive_r;
	wire is_active = scheme_i == SCH_ACTIVE_SERIAL || scheme_i == SCH_ACTIVE_PARALLEL;
	wire in_init = state_r == ST_INIT;
	wire ceo_release = dual_purpose_i && state_r == ST_USER;

	// Initialization delay runs only while the flow is initializing
	cscc_init_timer cscc_init_timer_i (
		.clk_i(clk_i),
		.srst_i(srst_i),
		.run_i(in_init),
		.done_o(init_done)
	);

	// =========================================
	// Flow
	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			ST_RESET:
			begin
				if (!reconf_low && chain_ok)
					state_nxt = ST_CONFIG;
			end
			ST_CONFIG:
			begin
				if (ext_error || crc_err_i)
					state_nxt = ST_ERROR;
				else if (data_done_i && chain_ok)
					state_nxt = ST_WAIT_DONE;
			end
			// Done line is already released here; wait for the board to let it rise
			ST_WAIT_DONE:
			begin
				if (ext_error)
					state_nxt = ST_ERROR;
				else if (config_done_status_i)
					state_nxt = ST_INIT;
			end
			ST_INIT:
			begin
				if (ext_error)
					state_nxt = ST_ERROR;
				else if (init_done)
					state_nxt = ST_USER;
			end
			// Done and error lines are ignored once running
			ST_USER:
			begin
				state_nxt = ST_USER;
			end
			ST_ERROR:
			begin
				state_nxt = ST_ERROR;
			end
			default:
			begin
				state_nxt = ST_RESET;
			end
		endcase
		// Request low holds the flow in reset; its rising edge restarts it
		if (reconf_low || reconf_rise)
			state_nxt = ST_RESET;
	end

	// Done line driven low until all data is in, then released unless the flow enters its error state or restarts
	assign done_drive_nxt = state_nxt == ST_RESET || state_nxt == ST_CONFIG || state_nxt == ST_ERROR;
	// Chain output pulled low once own configuration is complete
	assign ceo_drive_nxt = state_nxt == ST_WAIT_DONE || state_nxt == ST_INIT || state_nxt == ST_USER;
	// Flash selected only while an active scheme fetches data
	assign fsel_n_nxt = ~(state_nxt == ST_CONFIG && is_active);
	// Error line pulled low while the flow sits in its error state
	assign err_drive_nxt = state_nxt == ST_ERROR;

	// =========================================
	// Flow register
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
			state_r <= ST_RESET;
		else
			state_r <= state_nxt;
	end

	// =========================================
	// Reconfiguration request history
	// Reset to the idle high level so that leaving reset is not taken for a rising request
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
			reconf_prev_r <= RECONF_PREV_RST;
		else
			reconf_prev_r <= reconfig_request_n_i;
	end

	// =========================================
	// Pin drive registers
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
			done_drive_r <= DONE_DRIVE_RST;
		else
			done_drive_r <= done_drive_nxt;
	end

	always_ff @(posedge clk_i)
	begin
		if (srst_i)
			ceo_drive_r <= CEO_DRIVE_RST;
		else
			ceo_drive_r <= ceo_drive_nxt;
	end

	always_ff @(posedge clk_i)
	begin
		if (srst_i)
			fsel_n_r <= FSEL_N_RST;
		else
			fsel_n_r <= fsel_n_nxt;
	end

	always_ff @(posedge clk_i)
	begin
		if (srst_i)
			err_drive_r <= ERR_DRIVE_RST;
		else
			err_drive_r <= err_drive_nxt;
	end

	// =========================================
	// Pins
	assign config_done_status_o = 1'b0;
	assign config_done_status_oe_o = done_drive_r;
	assign config_error_n_o = 1'b0;
	assign config_error_n_oe_o = err_drive_r;
	assign chain_enable_out_n_o = 1'b0;
	// Dual-purpose: release in user mode so the pin is user I/O
	assign chain_enable_out_n_oe_o = ceo_drive_r && !ceo_release;
	assign flash_select_n_o = fsel_n_r;

	// =========================================
	// Flow status
	assign config_active_o = state_r == ST_CONFIG;
	assign user_mode_o = state_r == ST_USER;
	assign error_o = state_r == ST_ERROR;

endmodule : cscc_ctrl

// ### cscc_ctrl_properties.sv
// Port checker for cscc_ctrl; assumes one clock domain and the bind at the foot.
module cscc_ctrl_properties
	import cscc_pkg::*;
(
	// Watched ports
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic config_active_o,
	input wire logic user_mode_o,
	input wire logic error_o,
	input wire logic reconfig_request_n_i,
	input wire logic chain_enable_in_n_i,
	input wire logic config_done_status_oe_o,
	input wire logic config_error_n_oe_o,
	input wire logic chain_enable_out_n_oe_o,
	input wire logic flash_select_n_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (srst_i);
	AST_DONE_HELD: assert property (config_active_o |-> config_done_status_oe_o) else $error("done freed");
	AST_DONE_FREE: assert property (user_mode_o |-> !config_done_status_oe_o) else $error("done held");
	AST_NO_SKIP: assert property (config_active_o |=> !user_mode_o) else $error("init skipped");
	AST_USER_KEEP: assert property (user_mode_o && reconfig_request_n_i |=> user_mode_o) else $error("user lost");
	AST_GATE: assert property (chain_enable_in_n_i && !config_active_o |=> !config_active_o) else $error("gate");
	AST_FLASH_IDLE: assert property (!config_active_o |-> flash_select_n_o) else $error("flash on");
	AST_RESTART: assert property (!reconfig_request_n_i |=> !(config_active_o || user_mode_o)) else $error("no reset");
	AST_ERR_STICKY: assert property (error_o && reconfig_request_n_i |=> error_o) else $error("error lost");
	AST_ERR_DRIVE: assert property (error_o |-> config_error_n_oe_o) else $error("error line free");
	AST_CHAIN_WAIT: assert property (config_active_o |-> !chain_enable_out_n_oe_o) else $error("chain early");
	cover property (user_mode_o);
	cover property (error_o);
	cover property (config_active_o && !flash_select_n_o);
endmodule : cscc_ctrl_properties
bind cscc_ctrl cscc_ctrl_properties cscc_ctrl_properties_i (.*);

// ### cscc_partner.sv
// Board model: pulled-up done and error lines that the block or the host may pull low.
// Assumes every pull-down enable is high while pulling.
module cscc_partner (
	// Pull-down sources
	input wire logic done_oe_i,
	input wire logic hold_i,
	input wire logic err_oe_i,
	input wire logic err_hold_i,
	// Resolved levels
	output logic done_o,
	output logic err_o
);
	timeunit 1ns / 1ns;
	assign done_o = !(done_oe_i || hold_i);
	assign err_o = !(err_oe_i || err_hold_i);
endmodule : cscc_partner

// ### cscc_ctrl_bench.sv
// Bench for cscc_ctrl; assumes inputs are sampled on the rising edge of clk_i.
module cscc_ctrl_bench
	import cscc_pkg::*;
;
	timeunit 1ns / 1ns;
	logic clk_i = 1'b0, srst_i = 1'b1, dd = 1'b0, crc = 1'b0, req_n = 1'b0, ce_n = 1'b0, hold = 1'b1, ehold = 1'b0;
	logic act, usr, err, done_ln, done_oe, err_ln, err_oe, co_oe, fl_n, done_c, err_c, co_c;
	cscc_scheme_t sch = SCH_PASSIVE;
	int failures = 0, checks = 0, n;
	always #25 clk_i = ~clk_i;
	cscc_ctrl cscc_ctrl_i (.clk_i, .srst_i, .scheme_i(sch), .dual_purpose_i(sch[0]), .data_done_i(dd),
		.crc_err_i(crc), .config_active_o(act), .user_mode_o(usr), .error_o(err), .reconfig_request_n_i(req_n),
		.chain_enable_in_n_i(ce_n), .config_done_status_i(done_ln), .config_done_status_o(done_c),
		.config_done_status_oe_o(done_oe), .config_error_n_i(err_ln), .config_error_n_o(err_c),
		.config_error_n_oe_o(err_oe), .chain_enable_out_n_o(co_c), .chain_enable_out_n_oe_o(co_oe),
		.flash_select_n_o(fl_n));
	cscc_partner cscc_partner_i (.done_oe_i(done_oe), .hold_i(hold), .done_o(done_ln), .err_oe_i(err_oe),
		.err_hold_i(ehold), .err_o(err_ln));
	task chk(input logic e, input logic g);
		checks++;
		failures += (g !== e);
		if (g !== e) $display("mismatch t=%0t exp=%h got=%h", $time, e, g);
	endtask : chk
	task wrap_up;
		$display("failures=%0d checks=%0d", failures, checks);
		if (failures == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : wrap_up
	task wait_on(input logic u);
		for (n = 0; n < 60 && (u ? usr : act) !== 1'b1; n++) @(posedge clk_i);
		chk(1'b1, n < 60);
		if (n == 60) wrap_up();
	endtask : wait_on
	task run_flow(input cscc_scheme_t s);
		@(posedge clk_i) req_n <= 1'b0;
		sch <= s;
		dd <= 1'b0;
		@(posedge clk_i) req_n <= 1'b1;
		wait_on(1'b0);
		chk(s == SCH_PASSIVE, fl_n);
		chk(1'b1, done_oe);
		chk(1'b0, co_oe);
		dd <= 1'b1;
		repeat (30) @(posedge clk_i);
		chk(1'b0, usr);
		chk(1'b0, done_oe);
		hold <= 1'b0;
		wait_on(1'b1);
		hold <= 1'b1;
		repeat (5) @(posedge clk_i);
		chk(1'b1, usr);
		chk(~s[0], co_oe);
		chk(1'b0, done_c | err_c | co_c);
	endtask : run_flow
	task gate_and_fault;
		@(posedge clk_i) req_n <= 1'b0;
		ce_n <= 1'b1;
		dd <= 1'b0;
		@(posedge clk_i) req_n <= 1'b1;
		repeat (10) @(posedge clk_i);
		chk(1'b0, act);
		ce_n <= 1'b0;
		wait_on(1'b0);
		crc <= 1'b1;
		repeat (3) @(posedge clk_i);
		chk(1'b1, err);
		chk(1'b1, err_oe);
		@(posedge clk_i) req_n <= 1'b0;
		crc <= 1'b0;
		@(posedge clk_i) req_n <= 1'b1;
		wait_on(1'b0);
		chk(1'b0, err);
		ehold <= 1'b1;
		repeat (3) @(posedge clk_i);
		chk(1'b1, err);
		ehold <= 1'b0;
	endtask : gate_and_fault
	initial
	begin
		repeat (2) @(posedge clk_i);
		srst_i <= 1'b0;
		for (int i = 0; i < 3; i++) run_flow(cscc_scheme_t'(i));
		gate_and_fault();
		wrap_up();
	end
endmodule : cscc_ctrl_bench
